// ### inc/lpic_defs.svh
`ifndef LPIC_DEFS_SVH
`define LPIC_DEFS_SVH

// Register map
`define LPIC_ADDR_MASTER    8'h0E
`define LPIC_ADDR_INT_FIRST 8'h10
`define LPIC_ADDR_INT_LAST  8'h17
`define LPIC_ADDR_INT_BASE  5'h02

// Field positions of the master/global register
`define LPIC_MASTER_MSB     7
`define LPIC_MASTER_LSB     4
`define LPIC_GLOBAL_MSB     3
`define LPIC_GLOBAL_LSB     0

// Reset values
`define LPIC_MASTER_RST     8'h00
`define LPIC_INT_RST        8'h00
`define LPIC_RDATA_RST      8'h00
`define LPIC_UNMAPPED_RD    8'h00

// Codes and counts
`define LPIC_MASTER_OFF     4'h0
`define LPIC_INT_STATIC     4'hF
`define LPIC_SLOT_LAST      4'hE
`define LPIC_CYC_LAST       4'hF
`define LPIC_PORTS          17
`define LPIC_EXTRA_PORT     16
`define LPIC_INT_REGS       8

`endif

// ### inc/lpic_pkg.sv
`include "lpic_defs.svh"

package lpic_pkg;

  typedef logic [3:0] lpic_nib_t;

  typedef struct packed {
    lpic_nib_t slot;
    lpic_nib_t cyc;
  } lpic_tb_s;

  typedef struct packed {
    logic [7:0]                           master;
    logic [`LPIC_INT_REGS-1:0][7:0]       intens;
    logic [7:0]                           rdata;
    logic [`LPIC_PORTS-1:0]               drv_low;
  } lpic_core_s;

endpackage

// ### hw/lpic_timebase.sv
`timescale 1ns/1ps
`include "lpic_defs.svh"

module lpic_timebase
  import lpic_pkg::*;
(
  input  wire logic      core_clk_i,  // Step clock
  input  wire logic      rst_i,       // Async reset, active high
  output lpic_nib_t      slot_o,      // Timeslot 0..14
  output lpic_nib_t      cyc_o        // PWM cycle 0..15
);

  lpic_tb_s s;
  lpic_tb_s next_s;

  // 240-step period: 15 timeslots of 16 cycles
  always_comb begin
    next_s = s;
    if (s.cyc == `LPIC_CYC_LAST) begin
      next_s.cyc  = 4'h0;
      next_s.slot = (s.slot == `LPIC_SLOT_LAST) ? 4'h0
                                                : 4'(s.slot + 4'h1);
    end else begin
      next_s.cyc = 4'(s.cyc + 4'h1);
    end
  end

  // Restarts at the first step of a period after reset
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign slot_o = s.slot;
  assign cyc_o  = s.cyc;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_period_end;
    s.slot == `LPIC_SLOT_LAST && s.cyc == `LPIC_CYC_LAST;
  endsequence

  sequence seq_period_start;
    s.slot == 4'h0 && s.cyc == 4'h0 ##1 s.cyc == 4'h1;
  endsequence

  a_period_wrap: assert property (
    seq_period_end |=> seq_period_start)
    else $error("period did not wrap after step 240");

  a_slot_advance: assert property (
    (s.cyc == `LPIC_CYC_LAST && s.slot != `LPIC_SLOT_LAST)
      |=> s.slot == $past(s.slot) + 4'h1 && s.cyc == 4'h0)
    else $error("timeslot did not advance after 16 cycles");

  a_slot_range: assert property (
    s.slot <= `LPIC_SLOT_LAST)
    else $error("timeslot beyond 15 slots");

endmodule // lpic_timebase

// ### hw/lpic_top.sv
`timescale 1ns/1ps
`include "lpic_defs.svh"

// Contract
// - A master field of zero makes every output static, set only by its phase bit.
// - With master nonzero and global select clear, each output but the extra port uses its own.
// - An individual intensity of 0xF gives a static output with no PWM.
// - Individual intensities 0x0 to 0xE drive the output with PWM.
// - Master nonzero and global select set: one nibble drives every output.
// - Setting n drives low (n+1)/16 of each enabled timeslot; phase bit 1 swaps low/high.
// - Setting 0xF holds low for phase bit 0 and released for phase bit 1.
// - The period is 240 steps: 15 timeslots of 16 cycles each.
// - The master value enables 1 to 15 timeslots; 16/16 bypasses the gate.
// - The phase 0 bit sets the level taken during the PWM on-time.
// - The extra port's nibble doubles as the global intensity value.
module lpic_top
  import lpic_pkg::*;
(
  input  wire logic                    core_clk_i,   // Oscillator clock
  input  wire logic                    rst_i,        // Async reset, high
  input  wire logic                    reg_wr_i,     // Register write strobe
  input  wire logic                    reg_rd_i,     // Register read strobe
  input  wire logic [7:0]              reg_addr_i,   // Register address
  input  wire logic [7:0]              reg_wdata_i,  // Write data
  input  wire logic                    global_sel_i, // Global intensity on
  input  wire logic [`LPIC_PORTS-1:0]  phase0_i,     // Phase 0 level bits
  output logic [7:0]                   reg_rdata_o,  // Read data
  output logic [`LPIC_PORTS-1:0]       port_o,       // Pin value, always 0
  output logic [`LPIC_PORTS-1:0]       port_oe_o     // High: pull pin low
);

  lpic_core_s s;
  lpic_core_s next_s;
  lpic_nib_t  slot;
  lpic_nib_t  cyc;
  lpic_nib_t  master;
  lpic_nib_t  glob;

  lpic_timebase u_timebase (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .slot_o     (slot),
    .cyc_o      (cyc)
  );

  assign master = s.master[`LPIC_MASTER_MSB:`LPIC_MASTER_LSB];
  assign glob   = s.master[`LPIC_GLOBAL_MSB:`LPIC_GLOBAL_LSB];

  // On-time of a PWM output: gated to the first m slots, then n+1 cycles
  function automatic logic pwm_on(input lpic_nib_t m, input lpic_nib_t n,
                                  input lpic_nib_t sl, input lpic_nib_t cy);
    return (sl < m) && (cy <= n);
  endfunction

  function automatic logic intens_addr(input logic [7:0] a);
    return a[7:3] == `LPIC_ADDR_INT_BASE;
  endfunction

  always_comb begin
    lpic_nib_t n;
    logic      active;
    n      = `LPIC_INT_STATIC;
    active = 1'b0;
    next_s = s;
    if (reg_wr_i) begin
      if (reg_addr_i == `LPIC_ADDR_MASTER) begin
        next_s.master = reg_wdata_i;
      end else if (intens_addr(reg_addr_i)) begin
        next_s.intens[reg_addr_i[2:0]] = reg_wdata_i;
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == `LPIC_ADDR_MASTER) begin
        next_s.rdata = s.master;
      end else if (intens_addr(reg_addr_i)) begin
        next_s.rdata = s.intens[reg_addr_i[2:0]];
      end else begin
        next_s.rdata = `LPIC_UNMAPPED_RD;
      end
    end
    for (int i = 0; i < `LPIC_PORTS; i++) begin
      // Low nibble drives the even port, high nibble the odd one
      if (i == `LPIC_EXTRA_PORT) begin
        n = glob;
      end else if (global_sel_i) begin
        n = glob;
      end else begin
        n = s.intens[3'(i / 2)][(i % 2) * 4 +: 4];
      end
      if (master == `LPIC_MASTER_OFF) begin
        active = 1'b1;
      end else if (n == `LPIC_INT_STATIC) begin
        active = 1'b1;
      end else begin
        active = pwm_on(master, n, slot, cyc);
      end
      // Phase bit 1 inverts, which swaps low and released times
      next_s.drv_low[i] = active ^ phase0_i[i];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s.master  <= `LPIC_MASTER_RST;
      s.intens  <= {`LPIC_INT_REGS{`LPIC_INT_RST}};
      s.rdata   <= `LPIC_RDATA_RST;
      s.drv_low <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata_o = s.rdata;
  assign port_oe_o   = s.drv_low;
  // Open drain: the pin is only ever pulled low, never driven high
  assign port_o      = '0;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_port0_pwm;
    master != `LPIC_MASTER_OFF && !global_sel_i
      && s.intens[0][3:0] != `LPIC_INT_STATIC;
  endsequence

  a_master_static: assert property (
    master == `LPIC_MASTER_OFF |=> port_oe_o == ~$past(phase0_i))
    else $error("master zero did not give static outputs");

  a_full_static: assert property (
    master != `LPIC_MASTER_OFF && !global_sel_i
      && s.intens[0][7:4] == `LPIC_INT_STATIC
      |=> port_oe_o[1] == ~$past(phase0_i[1]))
    else $error("intensity F output not static");

  a_pwm_low_time: assert property (
    seq_port0_pwm and (slot < master && cyc <= s.intens[0][3:0]
      && !phase0_i[0]) |=> port_oe_o[0])
    else $error("PWM low time not driven low");

  a_pwm_swapped: assert property (
    seq_port0_pwm and (slot < master && cyc > s.intens[0][3:0]
      && phase0_i[0]) |=> port_oe_o[0])
    else $error("swapped phase did not pull low in high time");

  a_gate_off: assert property (
    seq_port0_pwm and (slot >= master && !phase0_i[0])
      |=> !port_oe_o[0])
    else $error("output active outside master timeslots");

  a_global_same: assert property (
    master != `LPIC_MASTER_OFF && global_sel_i
      && phase0_i[3] == phase0_i[`LPIC_EXTRA_PORT]
      |=> port_oe_o[3] == port_oe_o[`LPIC_EXTRA_PORT])
    else $error("global intensity not shared by all outputs");

  a_master_wr_rd: assert property (
    reg_wr_i && reg_addr_i == `LPIC_ADDR_MASTER
      ##1 reg_rd_i && !reg_wr_i && reg_addr_i == `LPIC_ADDR_MASTER
      |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("master register read back mismatch");

  a_unmapped_rd: assert property (
    reg_rd_i && reg_addr_i != `LPIC_ADDR_MASTER && !intens_addr(reg_addr_i)
      |=> reg_rdata_o == `LPIC_UNMAPPED_RD)
    else $error("unmapped read not zero");

  // Read data only moves on a read strobe, so a slow host may sample late
  a_rdata_hold: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");

  sequence seq_intens_write;
    reg_wr_i && intens_addr(reg_addr_i);
  endsequence

  sequence seq_same_addr_read;
    reg_rd_i && !reg_wr_i && reg_addr_i == $past(reg_addr_i);
  endsequence

  a_intens_wr_rd: assert property (
    seq_intens_write ##1 seq_same_addr_read
      |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("intensity register read back mismatch");

  // A stray write must not disturb the gate setting
  a_master_keep: assert property (
    reg_wr_i && reg_addr_i != `LPIC_ADDR_MASTER |=> $stable(s.master))
    else $error("master field changed by another address");

  sequence seq_extra_static;
    master != `LPIC_MASTER_OFF && glob == `LPIC_INT_STATIC;
  endsequence

  // The extra port takes 16/16 from its own nibble in either mode
  a_extra_static: assert property (
    seq_extra_static |=> port_oe_o[`LPIC_EXTRA_PORT]
      == ~$past(phase0_i[`LPIC_EXTRA_PORT]))
    else $error("extra port at 16/16 not static");

  a_global_pwm: assert property (
    master != `LPIC_MASTER_OFF && global_sel_i && glob != `LPIC_INT_STATIC
      && slot < master && cyc <= glob && !phase0_i[0] |=> port_oe_o[0])
    else $error("global PWM low time not driven low");

  // Outside the enabled timeslots a global PWM output with phase bit 0 stays released
  a_global_gate: assert property (
    master != `LPIC_MASTER_OFF && global_sel_i && glob != `LPIC_INT_STATIC
      && slot >= master && !phase0_i[`LPIC_EXTRA_PORT]
      |=> !port_oe_o[`LPIC_EXTRA_PORT])
    else $error("global output active outside master timeslots");

  sequence seq_port2_pwm;
    master != `LPIC_MASTER_OFF && !global_sel_i
      && s.intens[1][3:0] != `LPIC_INT_STATIC;
  endsequence

  // Phase bit 1 turns the gated-off slots into low time as well
  a_gate_swapped: assert property (
    seq_port2_pwm and (slot >= master && phase0_i[2]) |=> port_oe_o[2])
    else $error("swapped phase released outside master timeslots");

endmodule // lpic_top

// ### sim/lpic_led_load.sv
`timescale 1ns/1ps
`include "lpic_defs.svh"

module lpic_led_load
  import lpic_pkg::*;
(
  input  wire logic [`LPIC_PORTS-1:0] port_i,    // Driven pin value
  input  wire logic [`LPIC_PORTS-1:0] port_oe_i, // High: pin pulled low
  output logic      [`LPIC_PORTS-1:0] pin_o      // Level at the load
);
  // Pull-up to the LED supply: a released pin reads high
  assign pin_o = (port_oe_i & port_i) | ~port_oe_i;
endmodule // lpic_led_load

// ### sim/led_pwm_intensity_control_tb_top.sv
`timescale 1ns/1ps
`include "lpic_defs.svh"

module led_pwm_intensity_control_tb_top
  import lpic_pkg::*;
;
  logic                   core_clk_i = 1'b0;
  logic                   rst_i      = 1'b1;
  logic                   reg_wr_i   = 1'b0;
  logic                   reg_rd_i   = 1'b0;
  logic [7:0]             reg_addr_i = 8'h00;
  logic [7:0]             reg_wdata_i = 8'h00;
  logic                   global_sel_i = 1'b0;
  logic [`LPIC_PORTS-1:0] phase0_i   = '0;
  logic [7:0]             reg_rdata_o;
  logic [`LPIC_PORTS-1:0] port_o;
  logic [`LPIC_PORTS-1:0] port_oe_o;
  logic [`LPIC_PORTS-1:0] pin;
  logic [8:0]             cnt [`LPIC_PORTS];
  int                     n_errors = 0;
  int                     n_tests  = 0;

  lpic_top DUT (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .global_sel_i(global_sel_i),
    .phase0_i(phase0_i), .reg_rdata_o(reg_rdata_o), .port_o(port_o),
    .port_oe_o(port_oe_o));

  lpic_led_load u_load (.port_i(port_o), .port_oe_i(port_oe_o), .pin_o(pin));

  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [8:0] seen,
                       input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check("reg_rdata_o", {1'b0, reg_rdata_o}, {1'b0, exp});
  endtask

  // Write, then read the same address on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check("wr_rd data", {1'b0, reg_rdata_o}, {1'b0, d});
  endtask

  task automatic wr_all(input logic [7:0] d);
    for (int i = 0; i < `LPIC_INT_REGS; i++) wr(8'h10 + 8'(i), d);
  endtask

  // Any 240 consecutive steps hold exactly one whole period
  task automatic measure();
    repeat (3) @(posedge core_clk_i);
    for (int p = 0; p < `LPIC_PORTS; p++) cnt[p] = '0;
    repeat (240) begin
      @(negedge core_clk_i);
      for (int p = 0; p < `LPIC_PORTS; p++) if (pin[p] === 1'b0) cnt[p]++;
    end
    @(posedge core_clk_i);
  endtask

  task automatic t_regs();
    rd(8'h0E, 8'h00);
    rd(8'h17, 8'h00);
    wr(8'h0E, 8'h35);
    rd(8'h0E, 8'h35);
    wr_rd(8'h0E, 8'h5A);
    wr_rd(8'h17, 8'hC3);
    wr(8'h20, 8'hAA);
    rd(8'h20, 8'h00);
  endtask

  task automatic t_static();
    wr(8'h0E, 8'h0F);
    wr_all(8'h00);
    global_sel_i <= 1'b1;
    phase0_i <= 17'h00020;
    measure();
    for (int p = 0; p < `LPIC_PORTS; p++)
      check("low steps", cnt[p], (p == 5) ? 9'd0 : 9'd240);
  endtask

  // Host keeps global select off while mixing static outputs
  task automatic t_mix();
    global_sel_i <= 1'b0;
    phase0_i <= 17'h0000C;
    wr(8'h0E, 8'h1F);
    wr(8'h10, 8'hF0);
    wr(8'h11, 8'hFE);
    measure();
    check("p0 n0", cnt[0], 9'd1);
    check("p1 nF", cnt[1], 9'd240);
    check("p2 nE inv", cnt[2], 9'd225);
    check("p3 nF inv", cnt[3], 9'd0);
    for (int p = 4; p < 16; p++) check("n0", cnt[p], 9'd1);
    check("extra nF", cnt[16], 9'd240);
  endtask

  task automatic t_duty();
    phase0_i <= 17'h00001;
    wr(8'h0E, 8'hF7);
    wr_all(8'h33);
    measure();
    check("p0 n3 inv", cnt[0], 9'd180);
    check("p1 n3", cnt[1], 9'd60);
    check("extra n7", cnt[16], 9'd120);
  endtask

  task automatic t_global();
    phase0_i <= '0;
    global_sel_i <= 1'b1;
    wr(8'h0E, 8'h53);
    wr_all(8'hFF);
    measure();
    for (int p = 0; p < `LPIC_PORTS; p++)
      check("global n3", cnt[p], 9'd20);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_errors++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge core_clk_i);
    check("released in reset", {8'h00, &pin}, 9'd1);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    check("static after reset", {8'h00, |pin}, 9'd0);
    t_regs();
    t_static();
    t_mix();
    t_duty();
    t_global();
    summarize();
  end
endmodule // led_pwm_intensity_control_tb_top
